/* File: hdl/pcsl_pkg.sv */
// Package: offsets, field positions and reset values of the port status and link capability block
package pcsl_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] PCSL_OFS_DEVCTL_STATUS = 8'hc8;
  localparam logic [7:0] PCSL_OFS_LINK_CAP = 8'hcc;
  localparam logic [7:0] PCSL_OFS_CAP_LOAD_INFO = 8'he0;
  localparam int PCSL_ADDR_W = 8;
  localparam int PCSL_DATA_W = 32;
  // ------------------------------------------------------------
  // Device control / status fields
  // ------------------------------------------------------------
  localparam int PCSL_CTL_ENABLE_LSB = 0;
  localparam int PCSL_NUM_ERR = 4;
  localparam int PCSL_STS_ERR_LSB = 16;
  localparam int PCSL_STS_AUX_BIT = 20;
  localparam int PCSL_STS_PEND_BIT = 21;
  localparam logic [3:0] PCSL_CTL_ENABLE_RST = 4'h0;
  localparam logic [3:0] PCSL_STS_ERR_RST = 4'h0;
  localparam logic PCSL_STS_AUX_RST = 1'b1;
  localparam logic PCSL_STS_PEND_VAL = 1'b0;
  // ------------------------------------------------------------
  // Link capability fields
  // ------------------------------------------------------------
  localparam int PCSL_CAP_SPEED_LSB = 0;
  localparam int PCSL_CAP_WIDTH_LSB = 4;
  localparam int PCSL_CAP_ASPM_LSB = 10;
  localparam int PCSL_CAP_L0S_LSB = 12;
  localparam int PCSL_CAP_L1_LSB = 15;
  localparam int PCSL_CAP_CLKPM_BIT = 18;
  localparam int PCSL_CAP_SDOWN_BIT = 19;
  localparam int PCSL_CAP_DLLA_BIT = 20;
  localparam int PCSL_CAP_BWN_BIT = 21;
  localparam int PCSL_CAP_PORT_LSB = 24;
  localparam logic [3:0] PCSL_SPEED_2G5 = 4'h1;
  localparam logic [3:0] PCSL_SPEED_5G0 = 4'h2;
  localparam logic [3:0] PCSL_CAP_SPEED_RST = 4'h2;
  localparam logic [5:0] PCSL_CAP_WIDTH_RST = 6'h01;
  localparam logic [1:0] PCSL_CAP_ASPM_RST = 2'h3;
  localparam logic [2:0] PCSL_CAP_L0S_RST = 3'h3;
  localparam logic [2:0] PCSL_CAP_L1_RST = 3'h0;
  localparam logic PCSL_CAP_DLLA_RST = 1'b0;
  // ------------------------------------------------------------
  // Default-load source codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {PCSL_SRC_NONE, PCSL_SRC_MGMT, PCSL_SRC_EEPROM} pcsl_src_t;
endpackage

/* File: hdl/pcsl_sync2.sv */
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module pcsl_sync2
  import pcsl_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;
endmodule // pcsl_sync2
`default_nettype wire

/* File: hdl/pcsl_sticky_flag.sv */
// Sticky event flag, cleared by a write of one
`timescale 1ns/1ps
`default_nettype none
module pcsl_sticky_flag
  import pcsl_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic setPulse,
  input wire logic clearPulse,
  output logic flag
);
  logic flag_reg;

  // Set wins over a clear in the same cycle, so no event is lost
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flag_reg <= RESET_VAL;
    else if (setPulse)
      flag_reg <= 1'b1;
    else if (clearPulse)
      flag_reg <= 1'b0;
  end

  assign flag = flag_reg;
endmodule // pcsl_sticky_flag
`default_nettype wire

/* File: hdl/pcsl_port_regs.sv */
// Per-port device status and link capability registers behind an Avalon-MM slave
// Notes on behaviour
// - Correctable error sets status bit 16, W1C
// - Non-fatal error sets status bit 17, W1C
// - Fatal error sets status bit 18, W1C
// - Unsupported request sets status bit 19, W1C
// - Flags log regardless of reporting enables
// - Bit 20 shows aux power, resets one
// - Bit 21 pending transactions always reads zero
// - Max link speed bits 3:0, reset 0010b
// - Max link width bits 9:4, single lane
// - ASPM support bits 11:10, reset 11b
// - L0s exit latency bits 14:12, reset 011b
// - L1 exit latency bits 17:15, reset 000b
// - Clock PM bit 18: upstream one, downstream zero
// - Surprise-down bit 19: upstream zero, downstream one
// - DLL-active reporting bit 20 is zero
// - Bandwidth notify bit 21: upstream zero, downstream one
// - Port number bits 31:24 from port index
// - ASPM, exit latency, clock PM and port number defaults replaceable by management bus or EEPROM
// - Control bits 0-3 enable error reporting, reset zero
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module pcsl_port_regs
  import pcsl_pkg::*;
#(
  parameter logic [7:0] PORT_INDEX = 8'h00,
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [3:0] MAX_SPEED = PCSL_CAP_SPEED_RST,
  parameter logic [5:0] MAX_WIDTH = PCSL_CAP_WIDTH_RST
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PCSL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [PCSL_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [PCSL_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic errCorrectable,
  input wire logic errNonFatal,
  input wire logic errFatal,
  input wire logic errUnsupported,
  input wire logic auxPowerPin,
  input wire logic mgmtLoadValid,
  input wire logic [PCSL_DATA_W-1:0] mgmtLoadData,
  input wire logic eepromLoadValid,
  input wire logic [PCSL_DATA_W-1:0] eepromLoadData,
  output logic [PCSL_NUM_ERR-1:0] errReport
);
  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Word decode, used by both read and write paths
  function automatic logic isWord(input logic [PCSL_ADDR_W-1:0] addr, input logic [7:0] ofs);
    isWord = (addr[PCSL_ADDR_W-1:2] == ofs[7:2]);
  endfunction

  // Byte-lane mask from byte enables
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // Reserved speed codes would mislead software, so fall back to the reset code
  function automatic logic [3:0] legalSpeed(input logic [3:0] code);
    if (code == PCSL_SPEED_2G5 || code == PCSL_SPEED_5G0)
      legalSpeed = code;
    else
      legalSpeed = PCSL_CAP_SPEED_RST;
  endfunction

  // A zero-lane width means nothing, so report a single lane instead
  function automatic logic [5:0] legalWidth(input logic [5:0] lanes);
    if (lanes == 6'h00)
      legalWidth = PCSL_CAP_WIDTH_RST;
    else
      legalWidth = lanes;
  endfunction

  localparam logic [3:0] CAP_SPEED = legalSpeed(MAX_SPEED);
  localparam logic [5:0] CAP_WIDTH = legalWidth(MAX_WIDTH);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic respPhase_reg;
  logic respPhase_next;
  logic [31:0] readData_reg;
  logic [31:0] readData_next;
  logic wrAccept;
  logic [31:0] wrMask;
  logic [3:0] errEvent;
  logic [3:0] errFlag;
  logic [3:0] errClear;
  logic [3:0] enable_reg;
  logic [3:0] errReport_reg;
  logic auxSync;
  logic auxPower_reg;
  logic [1:0] aspm_reg;
  logic [2:0] l0sExit_reg;
  logic [2:0] l1Exit_reg;
  logic clkPm_reg;
  logic [7:0] portNum_reg;
  logic loadValid;
  logic [31:0] loadData;
  pcsl_src_t loadSrc_reg;
  pcsl_src_t loadSrc_next;
  logic [7:0] loadCount_reg;
  logic [31:0] statusWord;
  logic [31:0] linkCapWord;
  logic [31:0] loadInfoWord;
  logic selStatus;
  logic selLinkCap;
  logic selLoadInfo;
  logic wrStatus;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  // One word select shared by read and write paths, so both agree
  always_comb
  begin
    selStatus = 1'b0;
    selLinkCap = 1'b0;
    selLoadInfo = 1'b0;
    if (isWord(avs_address, PCSL_OFS_DEVCTL_STATUS))
      selStatus = 1'b1;
    else if (isWord(avs_address, PCSL_OFS_LINK_CAP))
      selLinkCap = 1'b1;
    else if (isWord(avs_address, PCSL_OFS_CAP_LOAD_INFO))
      selLoadInfo = 1'b1;
  end

  assign wrStatus = wrAccept && selStatus;

  // ------------------------------------------------------------
  // Avalon-MM handshake
  // ------------------------------------------------------------
  // One wait cycle per access: read data is registered before release
  always_comb
  begin
    respPhase_next = 1'b0;
    if ((avs_read || avs_write) && !respPhase_reg)
      respPhase_next = 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      respPhase_reg <= 1'b0;
    else
      respPhase_reg <= respPhase_next;
  end

  assign avs_waitrequest = (avs_read || avs_write) && !respPhase_reg;
  assign wrAccept = avs_write && respPhase_reg;
  assign wrMask = laneMask(avs_byteenable) & avs_writedata;

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb
  begin
    statusWord = 32'h0000_0000;
    statusWord[PCSL_CTL_ENABLE_LSB +: PCSL_NUM_ERR] = enable_reg;
    statusWord[PCSL_STS_ERR_LSB +: PCSL_NUM_ERR] = errFlag;
    statusWord[PCSL_STS_AUX_BIT] = auxPower_reg;
    statusWord[PCSL_STS_PEND_BIT] = PCSL_STS_PEND_VAL;
  end

  // Bits 23:22 and reserved status bits stay zero
  always_comb
  begin
    linkCapWord = 32'h0000_0000;
    linkCapWord[PCSL_CAP_SPEED_LSB +: 4] = CAP_SPEED;
    linkCapWord[PCSL_CAP_WIDTH_LSB +: 6] = CAP_WIDTH;
    linkCapWord[PCSL_CAP_ASPM_LSB +: 2] = aspm_reg;
    linkCapWord[PCSL_CAP_L0S_LSB +: 3] = l0sExit_reg;
    linkCapWord[PCSL_CAP_L1_LSB +: 3] = l1Exit_reg;
    linkCapWord[PCSL_CAP_CLKPM_BIT] = clkPm_reg;
    linkCapWord[PCSL_CAP_SDOWN_BIT] = !IS_UPSTREAM;
    linkCapWord[PCSL_CAP_DLLA_BIT] = PCSL_CAP_DLLA_RST;
    linkCapWord[PCSL_CAP_BWN_BIT] = !IS_UPSTREAM;
    linkCapWord[PCSL_CAP_PORT_LSB +: 8] = portNum_reg;
  end

  always_comb
  begin
    loadInfoWord = 32'h0000_0000;
    loadInfoWord[1:0] = loadSrc_reg;
    loadInfoWord[15:8] = loadCount_reg;
  end

  // Unmapped addresses read as zero
  always_comb
  begin
    readData_next = readData_reg;
    if (avs_read && !respPhase_reg)
    begin
      if (selStatus)
        readData_next = statusWord;
      else if (selLinkCap)
        readData_next = linkCapWord;
      else if (selLoadInfo)
        readData_next = loadInfoWord;
      else
        readData_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      readData_reg <= 32'h0000_0000;
    else
      readData_reg <= readData_next;
  end

  assign avs_readdata = readData_reg;

  // ------------------------------------------------------------
  // Reporting enables
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      enable_reg <= PCSL_CTL_ENABLE_RST;
    else if (wrStatus && avs_byteenable[0])
      enable_reg <= avs_writedata[PCSL_CTL_ENABLE_LSB +: PCSL_NUM_ERR];
  end

  // ------------------------------------------------------------
  // Error flags
  // ------------------------------------------------------------
  assign errEvent = {errUnsupported, errFatal, errNonFatal, errCorrectable};

  // Clear only on the accepting edge, and only for lanes written
  always_comb
  begin
    errClear = 4'h0;
    if (wrStatus)
      errClear = wrMask[PCSL_STS_ERR_LSB +: PCSL_NUM_ERR];
  end

  // Logging ignores the enables; only the reported pulse uses them
  for (genvar i = 0; i < PCSL_NUM_ERR; i++)
  begin : g_err
    pcsl_sticky_flag #(
      .RESET_VAL(PCSL_STS_ERR_RST[i])
    ) u_flag (
      .clk_sys(clk_sys),
      .reset(reset),
      .setPulse(errEvent[i]),
      .clearPulse(errClear[i]),
      .flag(errFlag[i])
    );
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      errReport_reg <= 4'h0;
    else
      errReport_reg <= errEvent & enable_reg;
  end

  assign errReport = errReport_reg;

  // ------------------------------------------------------------
  // Auxiliary power detect
  // ------------------------------------------------------------
  // Pin is asynchronous, so it is synchronised before use
  pcsl_sync2 #(
    .RESET_VAL(PCSL_STS_AUX_RST)
  ) u_auxSync (
    .clk_sys(clk_sys),
    .reset(reset),
    .asyncIn(auxPowerPin),
    .syncOut(auxSync)
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      auxPower_reg <= PCSL_STS_AUX_RST;
    else
      auxPower_reg <= auxSync;
  end

  // ------------------------------------------------------------
  // Default reload
  // ------------------------------------------------------------
  // Management bus wins when both sources load in one cycle
  always_comb
  begin
    loadValid = mgmtLoadValid || eepromLoadValid;
    loadData = eepromLoadData;
    loadSrc_next = loadSrc_reg;
    if (mgmtLoadValid)
    begin
      loadData = mgmtLoadData;
      loadSrc_next = PCSL_SRC_MGMT;
    end
    else if (eepromLoadValid)
      loadSrc_next = PCSL_SRC_EEPROM;
  end

  // Bus writes never reach these fields
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      aspm_reg <= PCSL_CAP_ASPM_RST;
      l0sExit_reg <= PCSL_CAP_L0S_RST;
      l1Exit_reg <= PCSL_CAP_L1_RST;
      clkPm_reg <= IS_UPSTREAM;
      portNum_reg <= PORT_INDEX;
    end
    else if (loadValid)
    begin
      aspm_reg <= loadData[PCSL_CAP_ASPM_LSB +: 2];
      l0sExit_reg <= loadData[PCSL_CAP_L0S_LSB +: 3];
      l1Exit_reg <= loadData[PCSL_CAP_L1_LSB +: 3];
      clkPm_reg <= loadData[PCSL_CAP_CLKPM_BIT];
      portNum_reg <= loadData[PCSL_CAP_PORT_LSB +: 8];
    end
  end

  // Count saturates so software can tell a repeated load
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      loadSrc_reg <= PCSL_SRC_NONE;
      loadCount_reg <= 8'h00;
    end
    else if (loadValid)
    begin
      loadSrc_reg <= loadSrc_next;
      if (loadCount_reg != 8'hff)
        loadCount_reg <= loadCount_reg + 8'h01;
    end
  end
endmodule // pcsl_port_regs
`default_nettype wire

/* File: tb/pcsl_port_regs_properties.sv */
// Checker for the port status and link capability registers
`timescale 1ns/1ps
`default_nettype none
module pcsl_port_regs_properties
  import pcsl_pkg::*;
#(
  parameter logic [7:0] PORT_INDEX = 8'h00,
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [3:0] MAX_SPEED = 4'h2,
  parameter logic [5:0] MAX_WIDTH = 6'h01
)
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PCSL_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [PCSL_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [PCSL_DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic errCorrectable,
  input wire logic errNonFatal,
  input wire logic errFatal,
  input wire logic errUnsupported,
  input wire logic auxPowerPin,
  input wire logic mgmtLoadValid,
  input wire logic [PCSL_DATA_W-1:0] mgmtLoadData,
  input wire logic eepromLoadValid,
  input wire logic [PCSL_DATA_W-1:0] eepromLoadData,
  input wire logic [PCSL_NUM_ERR-1:0] errReport
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----
  // Reference state
  // ----
  localparam logic [31:0] LD_MASK = 32'hff07fc00;
  wire logic [5:0] wAddr = avs_address[7:2];
  wire logic acc = !avs_waitrequest;
  wire logic rdSts = avs_read && acc && wAddr == PCSL_OFS_DEVCTL_STATUS[7:2];
  wire logic rdCap = avs_read && acc && wAddr == PCSL_OFS_LINK_CAP[7:2];
  wire logic wrSts = avs_write && acc && wAddr == PCSL_OFS_DEVCTL_STATUS[7:2];
  wire logic rdOff = avs_read && acc && !rdSts && !rdCap && wAddr != PCSL_OFS_CAP_LOAD_INFO[7:2];
  wire logic [3:0] evt = {errUnsupported, errFatal, errNonFatal, errCorrectable};
  logic [3:0] flagModel_reg;
  logic [3:0] enModel_reg;
  logic [31:0] capModel_reg;
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      flagModel_reg <= 4'h0;
      enModel_reg <= 4'h0;
    end
    else
    begin
      // Set wins over a clear on the same edge
      flagModel_reg <= (flagModel_reg & ~(wrSts && avs_byteenable[2] ? avs_writedata[19:16] : 4'h0)) | evt;
      enModel_reg <= wrSts && avs_byteenable[0] ? avs_writedata[3:0] : enModel_reg;
    end
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      capModel_reg <= {PORT_INDEX, 2'h0, ~IS_UPSTREAM, 1'b0, ~IS_UPSTREAM, IS_UPSTREAM, 6'h03, 2'h3, MAX_WIDTH, MAX_SPEED};
    else if (mgmtLoadValid)
      capModel_reg <= (capModel_reg & ~LD_MASK) | (mgmtLoadData & LD_MASK);
    else if (eepromLoadValid)
      capModel_reg <= (capModel_reg & ~LD_MASK) | (eepromLoadData & LD_MASK);
  end
  // ----
  // Properties
  // ----
  a_flag_track: assert property (rdSts |-> avs_readdata[19:16] == $past(flagModel_reg))
    else $error("error flags differ from events");
  a_pend_zero: assert property (rdSts |-> avs_readdata[31:21] == 11'h000)
    else $error("pending or reserved status bit set");
  a_ctrl_bits: assert property (rdSts |-> avs_readdata[15:4] == 12'h000)
    else $error("unused control bits set");
  a_cap_value: assert property (rdCap |-> avs_readdata == $past(capModel_reg))
    else $error("link capability word wrong");
  a_cap_rsvd: assert property (rdCap |-> avs_readdata[23:20] == {3'h0, ~IS_UPSTREAM} << 1)
    else $error("capability bits 23:20 wrong");
  a_report_en: assert property (errReport == $past(evt & enModel_reg))
    else $error("error report not event and enable");
  a_unmapped_zero: assert property (rdOff |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  cover property (rdSts && avs_readdata[19:16] != 4'h0);
  cover property (mgmtLoadValid && eepromLoadValid);
  cover property (errReport != 4'h0);
endmodule // pcsl_port_regs_properties

bind pcsl_port_regs pcsl_port_regs_properties
#(.PORT_INDEX(PORT_INDEX), .IS_UPSTREAM(IS_UPSTREAM), .MAX_SPEED(MAX_SPEED), .MAX_WIDTH(MAX_WIDTH)) u_props
(
  .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .errCorrectable(errCorrectable), .errNonFatal(errNonFatal),
  .errFatal(errFatal), .errUnsupported(errUnsupported), .auxPowerPin(auxPowerPin),
  .mgmtLoadValid(mgmtLoadValid), .mgmtLoadData(mgmtLoadData), .eepromLoadValid(eepromLoadValid),
  .eepromLoadData(eepromLoadData), .errReport(errReport)
);
`default_nettype wire

/* File: tb/pcie_port_status_link_caps_tb.sv */
// Self-checking bench for the port status and link capability registers
`timescale 1ns/1ps
`default_nettype none
module pcie_port_status_link_caps_tb
  import pcsl_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [3:0] evt = 4'h0;
  logic auxPowerPin = 1'b1;
  logic mgmtLoadValid = 1'b0;
  logic eepromLoadValid = 1'b0;
  logic [31:0] mgmtLoadData = 32'h0;
  logic [31:0] eepromLoadData = 32'h0;
  wire logic [31:0] rdData;
  wire logic [31:0] rdData2;
  wire logic waitReq;
  wire logic [3:0] errReport;
  logic [31:0] q;
  logic [31:0] q2;
  int nFail = 0;
  int checkCount = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  // ----
  // Upstream port 0 and downstream port 3 share every input
  // ----
  pcsl_port_regs dut
  (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(rdData),
    .avs_waitrequest(waitReq), .errCorrectable(evt[0]), .errNonFatal(evt[1]), .errFatal(evt[2]),
    .errUnsupported(evt[3]), .auxPowerPin(auxPowerPin), .mgmtLoadValid(mgmtLoadValid),
    .mgmtLoadData(mgmtLoadData), .eepromLoadValid(eepromLoadValid), .eepromLoadData(eepromLoadData),
    .errReport(errReport)
  );
  pcsl_port_regs #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b0)) dut_down
  (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(rdData2),
    .avs_waitrequest(), .errCorrectable(evt[0]), .errNonFatal(evt[1]), .errFatal(evt[2]),
    .errUnsupported(evt[3]), .auxPowerPin(auxPowerPin), .mgmtLoadValid(mgmtLoadValid),
    .mgmtLoadData(mgmtLoadData), .eepromLoadValid(eepromLoadValid), .eepromLoadData(eepromLoadData),
    .errReport()
  );
  // ----
  // Tasks
  // ----
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checkCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request holds until waitrequest is seen low at a rising edge; only the timeout ends a hang
  task automatic xfer(input logic rd, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
    @(posedge clk_sys);
    avs_read <= rd;
    avs_write <= !rd;
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= be;
    @(posedge clk_sys);
    while (waitReq !== 1'b0)
      @(posedge clk_sys);
    q = rdData;
    q2 = rdData2;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic bus_read(input logic [7:0] addr, input logic [31:0] exp, input string name);
    xfer(1'b1, addr, 32'h0, 4'hf);
    check(name, exp, q);
  endtask
  task automatic pulse(input int i, input logic [3:0] expRep);
    @(posedge clk_sys);
    evt <= 4'h1 << i;
    @(posedge clk_sys);
    evt <= 4'h0;
    @(negedge clk_sys);
    check("errReport", {28'h0, expRep}, {28'h0, errReport});
  endtask
  task automatic load(input logic m, input logic e, input logic [31:0] md);
    @(posedge clk_sys);
    mgmtLoadValid <= m;
    eepromLoadValid <= e;
    mgmtLoadData <= md;
    eepromLoadData <= 32'h0;
    @(posedge clk_sys);
    mgmtLoadValid <= 1'b0;
    eepromLoadValid <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Sequence
  // ----
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      nFail++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus_read(8'hc8, 32'h0010_0000, "status reset");
    bus_read(8'hcc, 32'h0004_3c12, "caps up");
    check("caps down", 32'h0328_3c12, q2);
    for (int i = 0; i < 4; i++)
    begin
      pulse(i, 4'h0);
      bus_read(8'hc8, 32'h0010_0000 | (((32'h2 << i) - 32'h1) << 16), "flags");
    end
    xfer(1'b0, 8'hc8, 32'hffe5_ffff, 4'hf);
    bus_read(8'hc8, 32'h001a_000f, "w1c");
    for (int i = 0; i < 4; i++)
      pulse(i, 4'h1 << i);
    xfer(1'b0, 8'hc8, 32'h000f_0000, 4'hb);
    bus_read(8'hc8, 32'h001f_0000, "lane2 masked");
    xfer(1'b0, 8'hc8, 32'h000f_0000, 4'h4);
    bus_read(8'hc8, 32'h0010_0000, "cleared");
    auxPowerPin <= 1'b0;
    repeat (6) @(posedge clk_sys);
    bus_read(8'hc8, 32'h0, "aux off");
    auxPowerPin <= 1'b1;
    xfer(1'b0, 8'hcc, 32'hffff_ffff, 4'hf);
    bus_read(8'hcc, 32'h0004_3c12, "caps ro");
    xfer(1'b0, 8'hd4, 32'hffff_ffff, 4'hf);
    bus_read(8'hd4, 32'h0, "unmapped");
    load(1'b1, 1'b1, 32'hffff_ffff);
    bus_read(8'hcc, 32'hff07_fc12, "mgmt load");
    load(1'b0, 1'b1, 32'hffff_ffff);
    bus_read(8'hcc, 32'h0000_0012, "eeprom load");
    bus_read(8'he0, 32'h0000_0202, "load info");
    print_verdict();
  end
endmodule // pcie_port_status_link_caps_tb
`default_nettype wire
